//--- rtl/timer_pkg.sv
package timer_pkg;

    // ************************************************************
    // Register word offsets inside the timer block
    // ************************************************************
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_COUNTER = 4'h4;
    localparam logic [3:0] OFS_PERIOD = 4'h8;

    // ************************************************************
    // Control word bit positions
    // ************************************************************
    localparam int BIT_PIN_FUNCTION_SELECT = 0;
    localparam int BIT_IO_DIR = 1;
    localparam int BIT_DRIVE = 2;
    localparam int BIT_SENSE = 3;
    localparam int BIT_GO = 6;
    localparam int BIT_HOLD = 7;
    localparam int BIT_MODE = 8;
    localparam int BIT_CLOCK_SOURCE_SELECT = 9;
    localparam int BIT_INVERT = 10;
    localparam int BIT_STATUS = 11;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] RESET_CONTROL = 32'h0000_0000;
    localparam logic [31:0] RESET_COUNTER = 32'h0000_0000;
    localparam logic [31:0] RESET_PERIOD = 32'h0000_0000;

    // ************************************************************
    // Timing
    // ************************************************************
    // Internal count clock is the core clock divided by this figure
    localparam int INTERNAL_DIVIDE = 2;
    // External count clock must stay below core rate / 2.6
    localparam real EXT_CLOCK_MAX_RATIO = 2.6;

endpackage

//--- rtl/count_prescaler.sv
`timescale 1ns/1ps
module count_prescaler
    import timer_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Control
    input wire logic run_in,
    input wire logic clear_in,
    // Tick
    output logic tick_out
);

    typedef struct packed {
        logic [1:0] phase;
    } presc_state_t;

    presc_state_t s_r;
    presc_state_t s_nxt;

    // ************************************************************
    // Divide by two, frozen while held
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        tick_out = 1'b0;
        if (clear_in) begin
            s_nxt.phase = 2'h0;
        end else if (run_in) begin
            if (s_r.phase == 2'(INTERNAL_DIVIDE - 1)) begin
                s_nxt.phase = 2'h0;
                tick_out = 1'b1;
            end else begin
                s_nxt.phase = s_r.phase + 2'h1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

//--- rtl/count_edge_detect.sv
`timescale 1ns/1ps
module count_edge_detect (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Level to watch
    input wire logic level_in,
    // Rising edge, combinational
    output logic rise_out
);

    typedef struct packed {
        logic last;
    } edge_state_t;

    edge_state_t s_r;
    edge_state_t s_nxt;

    // ************************************************************
    // Rising edge of a level already synchronous to the clock
    // ************************************************************
    always_comb begin
        s_nxt.last = level_in;
        rise_out = level_in & ~s_r.last;
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

//--- rtl/periodic_timer_with_pin_io.sv
// Overview of operation
// - Go and release zero freeze everything, keep counter
// - Release alone resumes from previous state
// - Go without release stays held, go kept
// - Go with release zeroes counter and starts
// - 32-bit counter clears when increment equals period
// - Reset clears period and counter
// - Zero period and counter, pulse: status stays set
// - Zero period and counter, clock: two-cycle output
// - Zero period, nonzero counter counts to rollover
// - Counter above period wraps through all ones
// - Bus write beats internal counter or status update
// - Internal count clock is half core rate
// - Pulse mode status pulse lasts one cycle
// - Internal clock, gpio input: pin shown, drive ignored
// - Internal clock, gpio output: drive bit on pin
// - Internal clock, timer pin: pulse or clock output, optional invert
// - External clock, gpio input: count pin, optional invert
// - External clock, gpio output: count drive rising edges
// - External clock, timer pin: edge chosen by invert
// - Interrupt on every rising edge of status
// - Interrupt routed to processor and transfer engine
// - Clock mode gives fifty percent duty cycle
// - Hold also freezes prescaler and pin level
// - Start zeroes counter, go clears on first tick
`timescale 1ns/1ps
module periodic_timer_with_pin_io
    import timer_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Peripheral bus
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic [DATA_W-1:0] rdata_out,
    // Interrupt enables held outside
    input wire logic cpu_int_enable_in,
    input wire logic dma_int_enable_in,
    // Interrupt pulses
    output logic cpu_int_out,
    output logic dma_int_out,
    // Timer pin
    input wire logic timer_pin_in,
    output logic timer_pin_out,
    output logic timer_pin_oe_n_out
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic pin_function_select;
        logic io_direction;
        logic pin_drive_value;
        logic pin_sense_value;
        logic run_trigger;
        logic hold_release;
        logic clock_mode;
        logic clock_source_select;
        logic invert_select;
        logic timer_status_flag;
        logic [DATA_W-1:0] counter;
        logic [DATA_W-1:0] period;
        logic pin_level;
        logic pin_oe_n;
        logic [DATA_W-1:0] rdata;
        logic cpu_int;
        logic dma_int;
    } timer_state_t;

    timer_state_t s_r;
    timer_state_t s_nxt;

    logic internal_tick;
    logic external_rise;
    logic external_level;
    logic prescale_clear;
    logic ctrl_write;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [DATA_W-1:0] control_word(input timer_state_t st);
        logic [DATA_W-1:0] w;
        w = '0;
        w[BIT_PIN_FUNCTION_SELECT] = st.pin_function_select;
        w[BIT_IO_DIR] = st.io_direction;
        w[BIT_DRIVE] = st.pin_drive_value;
        w[BIT_SENSE] = st.pin_sense_value;
        w[BIT_GO] = st.run_trigger;
        w[BIT_HOLD] = st.hold_release;
        w[BIT_MODE] = st.clock_mode;
        w[BIT_CLOCK_SOURCE_SELECT] = st.clock_source_select;
        w[BIT_INVERT] = st.invert_select;
        w[BIT_STATUS] = st.timer_status_flag;
        return w;
    endfunction

    // ************************************************************
    // Control word decode
    // ************************************************************
    function automatic logic start_word(input logic [DATA_W-1:0] w);
        return w[BIT_GO] && w[BIT_HOLD];
    endfunction

    // ************************************************************
    // Pin ownership
    // ************************************************************
    function automatic logic gpio_output(input timer_state_t st);
        return !st.pin_function_select && st.io_direction;
    endfunction

    function automatic logic timer_output(input timer_state_t st);
        return st.pin_function_select && st.clock_source_select;
    endfunction

    // Gpio output counts its own drive bit, never inverted
    function automatic logic count_source(input timer_state_t st, input logic pin);
        logic lvl;
        lvl = pin ^ st.invert_select;
        if (gpio_output(st)) begin
            lvl = st.pin_drive_value;
        end
        return lvl;
    endfunction

    // ************************************************************
    // Register read
    // ************************************************************
    function automatic logic [DATA_W-1:0] read_word(input timer_state_t st, input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = '0;
        case (a)
            OFS_CONTROL: begin
                w = control_word(st);
            end
            OFS_COUNTER: begin
                w = st.counter;
            end
            OFS_PERIOD: begin
                w = st.period;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // ************************************************************
    // Count clock sources
    // ************************************************************
    assign external_level = count_source(s_r, timer_pin_in);

    assign ctrl_write = wr_en_in && (addr_in == OFS_CONTROL);
    // A start restarts the half-rate phase so the first tick is a full period
    assign prescale_clear = ctrl_write && start_word(wdata_in);

    count_prescaler u_prescaler (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .run_in(s_r.hold_release),
        .clear_in(prescale_clear),
        .tick_out(internal_tick)
    );

    count_edge_detect u_edge (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .level_in(external_level),
        .rise_out(external_rise)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic tick;
        logic degenerate;
        logic [DATA_W-1:0] base;
        logic [DATA_W-1:0] inc;
        tick = 1'b0;
        degenerate = 1'b0;
        base = '0;
        inc = '0;
        s_nxt = s_r;
        s_nxt.cpu_int = 1'b0;
        s_nxt.dma_int = 1'b0;

        tick = s_r.clock_source_select ? internal_tick : external_rise;
        degenerate = (s_r.period == '0) && ((s_r.counter == '0) || s_r.run_trigger);

        // Nothing moves unless released, so pin and status freeze as well
        if (s_r.hold_release) begin
            if (degenerate) begin
                if (s_r.clock_mode) begin
                    // External ticks are ignored here
                    s_nxt.timer_status_flag = ~s_r.timer_status_flag;
                end else begin
                    s_nxt.timer_status_flag = 1'b1;
                end
                s_nxt.counter = '0;
                if (tick) begin
                    s_nxt.run_trigger = 1'b0;
                end
            end else begin
                if (!s_r.clock_mode) begin
                    s_nxt.timer_status_flag = 1'b0;
                end
                if (s_r.run_trigger) begin
                    s_nxt.counter = '0;
                end
                if (tick) begin
                    base = s_r.run_trigger ? '0 : s_r.counter;
                    inc = base + 1'b1;
                    s_nxt.run_trigger = 1'b0;
                    if (inc == s_r.period) begin
                        s_nxt.counter = '0;
                        if (s_r.clock_mode) begin
                            s_nxt.timer_status_flag = ~s_r.timer_status_flag;
                        end else begin
                            s_nxt.timer_status_flag = 1'b1;
                        end
                    end else begin
                        s_nxt.counter = inc;
                    end
                end
            end
        end

        // ********************************************************
        // Bus writes take priority over internal updates
        // ********************************************************
        if (wr_en_in) begin
            case (addr_in)
                OFS_CONTROL: begin
                    s_nxt.pin_function_select = wdata_in[BIT_PIN_FUNCTION_SELECT];
                    s_nxt.io_direction = wdata_in[BIT_IO_DIR];
                    s_nxt.pin_drive_value = wdata_in[BIT_DRIVE];
                    // Go written low has no effect, so a pending go survives the hold
                    s_nxt.run_trigger = wdata_in[BIT_GO] || s_r.run_trigger;
                    s_nxt.hold_release = wdata_in[BIT_HOLD];
                    s_nxt.clock_mode = wdata_in[BIT_MODE];
                    s_nxt.clock_source_select = wdata_in[BIT_CLOCK_SOURCE_SELECT];
                    s_nxt.invert_select = wdata_in[BIT_INVERT];
                    // Status is read only, and the write cancels its update
                    s_nxt.timer_status_flag = s_r.timer_status_flag;
                    if (!wdata_in[BIT_GO] || !s_r.run_trigger) begin
                        s_nxt.counter = s_r.counter;
                    end
                    if (start_word(wdata_in)) begin
                        s_nxt.counter = '0;
                    end
                end
                OFS_COUNTER: begin
                    s_nxt.counter = wdata_in;
                end
                OFS_PERIOD: begin
                    s_nxt.period = wdata_in;
                end
                default: begin
                end
            endcase
        end

        // ********************************************************
        // Pin drive and sense
        // ********************************************************
        if (gpio_output(s_nxt)) begin
            s_nxt.pin_level = s_nxt.pin_drive_value;
            s_nxt.pin_oe_n = 1'b0;
        end else if (timer_output(s_nxt)) begin
            s_nxt.pin_level = s_nxt.timer_status_flag ^ s_nxt.invert_select;
            s_nxt.pin_oe_n = 1'b0;
        end else begin
            s_nxt.pin_level = 1'b0;
            s_nxt.pin_oe_n = 1'b1;
        end
        if (s_nxt.pin_oe_n) begin
            s_nxt.pin_sense_value = timer_pin_in;
        end else begin
            s_nxt.pin_sense_value = s_nxt.pin_level;
        end

        // ********************************************************
        // Interrupt on rising status
        // ********************************************************
        if (s_nxt.timer_status_flag && !s_r.timer_status_flag) begin
            s_nxt.cpu_int = cpu_int_enable_in;
            s_nxt.dma_int = dma_int_enable_in;
        end

        // ********************************************************
        // Registered read, unmapped words read zero
        // ********************************************************
        s_nxt.rdata = '0;
        if (rd_en_in) begin
            s_nxt.rdata = read_word(s_r, addr_in);
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_r <= '0;
            s_r.counter <= RESET_COUNTER;
            s_r.period <= RESET_PERIOD;
            s_r.pin_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdata_out = s_r.rdata;
    assign cpu_int_out = s_r.cpu_int;
    assign dma_int_out = s_r.dma_int;
    assign timer_pin_out = s_r.pin_level;
    assign timer_pin_oe_n_out = s_r.pin_oe_n;

endmodule

//--- test/timer_checker_assertions.sv
`timescale 1ns/1ps
module timer_checker
    import timer_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Bus
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic [DATA_W-1:0] rdata_out,
    // Interrupts
    input wire logic cpu_int_enable_in,
    input wire logic dma_int_enable_in,
    input wire logic cpu_int_out,
    input wire logic dma_int_out,
    // Pin
    input wire logic timer_pin_in,
    input wire logic timer_pin_out,
    input wire logic timer_pin_oe_n_out
);
    // Shadow of the last control write; only static bits are used from it
    logic [DATA_W-1:0] ctrl_r;
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl_r <= '0;
        end else if (wr_en_in && addr_in == OFS_CONTROL) begin
            ctrl_r <= wdata_in;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // ****
    // Checks
    // ****
    reset_quiet_a: assert property (
        disable iff (1'b0) rst_in |=> rdata_out == '0 && timer_pin_oe_n_out && !cpu_int_out && !dma_int_out)
        else $error("outputs not quiet after reset");
    read_idle_a: assert property (!rd_en_in |=> rdata_out == '0)
        else $error("read data without read");
    int_pulse_a: assert property (cpu_int_out |=> !cpu_int_out)
        else $error("interrupt longer than one cycle");
    int_route_a: assert property (
        cpu_int_enable_in && dma_int_enable_in && $past(cpu_int_enable_in) && $past(dma_int_enable_in)
        |-> cpu_int_out == dma_int_out) else $error("interrupt routes differ");
    hold_freeze_a: assert property (
        !ctrl_r[BIT_HOLD] && !wr_en_in |=> $stable(timer_pin_out) && !cpu_int_out)
        else $error("activity while held");
    gpio_in_a: assert property (!ctrl_r[BIT_PIN_FUNCTION_SELECT] && !ctrl_r[BIT_IO_DIR] |-> timer_pin_oe_n_out)
        else $error("pin driven in input mode");
    gpio_out_a: assert property (!ctrl_r[BIT_PIN_FUNCTION_SELECT] && ctrl_r[BIT_IO_DIR]
        |-> !timer_pin_oe_n_out && timer_pin_out == ctrl_r[BIT_DRIVE]) else $error("drive bit not on pin");
    timer_pin_a: assert property (ctrl_r[BIT_PIN_FUNCTION_SELECT] |-> timer_pin_oe_n_out == !ctrl_r[BIT_CLOCK_SOURCE_SELECT])
        else $error("pin direction wrong in timer mode");
endmodule

bind periodic_timer_with_pin_io timer_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_timer_checker (
    .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .cpu_int_enable_in(cpu_int_enable_in),
    .dma_int_enable_in(dma_int_enable_in), .cpu_int_out(cpu_int_out), .dma_int_out(dma_int_out),
    .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out), .timer_pin_oe_n_out(timer_pin_oe_n_out));

//--- test/pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
    // Clock
    input wire logic clock_in,
    // Device side of the pin
    input wire logic drive_in,
    input wire logic oe_n_in,
    // Resolved pin level
    output logic pin_out
);
    logic ext_r = 1'b0;
    // Pull-down: the pin rests low when nobody drives it
    assign pin_out = !oe_n_in ? drive_in : ext_r;
    // Six core cycles a period keeps below the core rate over 2.6
    task automatic burst(input int n);
        repeat (n) begin
            repeat (3) @(negedge clock_in);
            ext_r = 1'b1;
            repeat (3) @(negedge clock_in);
            ext_r = 1'b0;
        end
    endtask
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
    import timer_pkg::*;
    logic clock_in, rst_in, wr_en, rd_en, cpu_en, dma_en;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, v1, v2;
    logic pin_in, pin_out, oe_n, cpu_int, dma_int;
    int error_cnt, num_checks, n_cpu, n_dma, n_pin;
    logic [31:0] ext_words [4] = '{32'h0c1, 32'h4c1, 32'h0c0, 32'h4c0};

    periodic_timer_with_pin_io i_periodic_timer_with_pin_io (.clock_in(clock_in), .rst_in(rst_in),
        .addr_in(addr), .wr_en_in(wr_en), .rd_en_in(rd_en), .wdata_in(wdata), .rdata_out(rdata),
        .cpu_int_enable_in(cpu_en), .dma_int_enable_in(dma_en), .cpu_int_out(cpu_int),
        .dma_int_out(dma_int), .timer_pin_in(pin_in), .timer_pin_out(pin_out), .timer_pin_oe_n_out(oe_n));
    pin_partner i_pin_partner (.clock_in(clock_in), .drive_in(pin_out), .oe_n_in(oe_n), .pin_out(pin_in));

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    // ****
    // Bus and check tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(negedge clock_in);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clock_in);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(negedge clock_in);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock_in);
        rd_en = 1'b0;
        d = rdata;
    endtask
    // Halt, configure with run bits low, load registers, then run
    task automatic start(input logic [31:0] p, input logic [31:0] c, input logic [31:0] w);
        wr(4'h0, 32'h0);
        wr(4'h0, w & 32'hf3f);
        wr(4'h8, p);
        wr(4'h4, c);
        wr(4'h0, w);
    endtask
    task automatic cnt(input int n);
        n_cpu = 0;
        n_dma = 0;
        n_pin = 0;
        repeat (n) begin
            @(negedge clock_in);
            n_cpu += int'(cpu_int);
            n_dma += int'(dma_int);
            n_pin += int'(pin_out);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        for (int a = 0; a < 16; a += 4) begin
            rd(a[3:0], v1);
            chk(v1, 32'h0, "reset value");
        end
        $display("reset test done");
    endtask
    task automatic t_hold;
        start(32'h1000, 32'h5, 32'h240);
        repeat (6) @(negedge clock_in);
        rd(4'h0, v1);
        chk(v1[BIT_GO], 1, "go kept");
        rd(4'h4, v1);
        chk(v1, 32'h5, "held count");
        wr(4'h0, 32'h2c0);
        rd(4'h4, v1);
        chk(v1 < 2, 1, "start clears");
        rd(4'h4, v1);
        repeat (18) @(negedge clock_in);
        rd(4'h4, v2);
        chk(v2 - v1, 32'd10, "count rate");
        wr(4'h0, 32'h200);
        rd(4'h4, v1);
        repeat (10) @(negedge clock_in);
        rd(4'h4, v2);
        chk(v2, v1, "frozen");
        wr(4'h0, 32'h280);
        repeat (10) @(negedge clock_in);
        rd(4'h4, v1);
        chk((v1 - v2) inside {[5:7]}, 1, "resume");
        $display("hold test done");
    endtask
    // Period 3 pulse mode with and without inversion and dma route
    task automatic t_pulse;
        for (int i = 0; i < 2; i++) begin
            dma_en = i[0];
            start(32'h3, 32'h0, i ? 32'h6c1 : 32'h2c1);
            repeat (10) @(negedge clock_in);
            cnt(60);
            chk(n_cpu, 10, "match ints");
            chk(n_dma, 10 * i, "dma route");
            chk(n_pin, i ? 50 : 10, "pulse width");
        end
        $display("pulse test done");
    endtask
    task automatic t_wrap;
        wr(4'h0, 32'h0);
        wr(4'h8, 32'h0);
        wr(4'h4, 32'hffff_fffe);
        wr(4'h0, 32'h280);
        rd(4'h4, v1);
        chk(v1 > 32'hffff_fffc, 1, "above period");
        repeat (20) @(negedge clock_in);
        rd(4'h0, v1);
        chk(v1[BIT_STATUS], 1, "status stays");
        $display("wrap test done");
    endtask
    task automatic t_clock;
        for (int i = 0; i < 2; i++) begin
            start(2 * i, 32'h0, 32'h3c1);
            repeat (10) @(negedge clock_in);
            cnt(40);
            chk(n_pin, 20, "duty");
            chk(n_cpu, i ? 5 : 20, "clock ints");
        end
        $display("clock test done");
    endtask
    task automatic t_ext_out;
        start(32'h100, 32'h0, 32'h0c2);
        wr(4'h0, 32'h086);
        wr(4'h0, 32'h082);
        wr(4'h0, 32'h086);
        repeat (4) @(negedge clock_in);
        rd(4'h4, v1);
        chk(v1, 32'h2, "drive edges");
        rd(4'h0, v1);
        chk(v1[BIT_SENSE], 1, "sense drive");
        $display("drive test done");
    endtask
    task automatic t_ext_in;
        foreach (ext_words[i]) begin
            start(32'h100, 32'h0, ext_words[i]);
            i_pin_partner.burst(5);
            repeat (4) @(negedge clock_in);
            rd(4'h4, v1);
            chk(v1, 32'h5, "pin edges");
        end
        wr(4'h0, 32'h204);
        repeat (3) @(negedge clock_in);
        rd(4'h0, v1);
        chk(v1[BIT_SENSE], 0, "sense input");
        $display("pin input test done");
    endtask

    initial begin
        rst_in = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        cpu_en = 1'b1;
        dma_en = 1'b0;
        repeat (8) @(negedge clock_in);
        rst_in = 1'b0;
        t_reset;
        t_hold;
        t_pulse;
        t_wrap;
        t_clock;
        t_ext_out;
        t_ext_in;
        report_and_stop;
    end
    // Whole run needs well under two thousand cycles
    initial begin
        #400000;
        error_cnt++;
        report_and_stop;
    end
endmodule
